// File: rtl/ssfb_top.sv
// Command interpreter for the clock-synchronous serial flash boot mode
// What this block does
// - Sync mode entered if clock high at reset
// - Sample input bits on transfer clock rise
// - Drive output bits on transfer clock fall
// - Bytes are eight bits, LSB first
// - Busy high unless ready for next transfer
// - Page read: FF, address middle, address high
// - Page read returns 256 bytes, ascending
// - Status read returns status, then extended status
// - Erase all needs A7 then D0
// - Lock query: 71, two addresses, lock byte
// - Download: FA, size low/high, checksum, data
// - Version command outputs transfers two to nine
// - Boot output: FC, two addresses, 256 bytes
// - Without ID only status, ID, version accepted
// - Blank flash accepts every command
// - Output bytes from device, all others inbound
// - Status shows ready state and error results
// - Page program: 41, two addresses, 256 data
// - Block erase: 20, two addresses, then D0
// - Command 50 clears error bits, busy drops
// - Lock program: 77, two addresses, then D0
module ssfb_top (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic xfer_clock_pin,
	input wire logic serial_in_pin,
	input wire logic [7:0] fl_rdata,
	input wire logic fl_done,
	input wire logic fl_fail,
	input wire logic flash_blank,
	input wire logic id_verified,
	output logic serial_out_pin,
	output logic busy_out_pin,
	output logic mode_active_q,
	output logic [23:0] fl_addr_q,
	output logic [7:0] fl_wdata_q,
	output logic fl_rd_q,
	output logic fl_boot_q,
	output logic fl_wr_q,
	output logic fl_erase_blk_q,
	output logic fl_erase_all_q,
	output logic fl_lock_prog_q,
	output logic fl_lock_rd_q,
	output logic lock_enable_q,
	output logic lock_disable_q,
	output logic dl_valid_q,
	output logic [7:0] dl_data_q,
	output logic dl_exec_q
);
	ssfb_pkg::ssfb_state_t state_q;
	logic [8:0] idx_q;
	logic [7:0] cmd_q, rx_q, addr_mid_q, addr_hi_q, sum_q, chk_q, tx_data_q;
	logic [15:0] size_q, cnt_q;
	logic [1:0] cap_cnt_q;
	logic prog_fail_q, erase_fail_q, op_erase_q, tx_load_q;
	logic [7:0] rx_byte, ver_byte, status_w, status_ext_w, rd_off_w, wr_off_w, addr_hi_w;
	logic byte_done, rx_active, sclk_level;
	logic first_w, accept_w, clear_w, err_set_w, last_cnt_w, page_end_w;
	logic [2:0] ver_idx_w;
	logic [15:0] cnt_inc_w;

	// Every code the interpreter knows
	function automatic logic is_known(input logic [7:0] c);
		case (c)
			ssfb_pkg::CMD_PAGE_READ, ssfb_pkg::CMD_PAGE_PROG, ssfb_pkg::CMD_BLK_ERASE,
			ssfb_pkg::CMD_ERASE_ALL, ssfb_pkg::CMD_STAT_RD, ssfb_pkg::CMD_STAT_CLR,
			ssfb_pkg::CMD_LOCK_RD, ssfb_pkg::CMD_LOCK_PROG, ssfb_pkg::CMD_LOCK_EN,
			ssfb_pkg::CMD_LOCK_DIS, ssfb_pkg::CMD_ID_CHECK, ssfb_pkg::CMD_DOWNLOAD,
			ssfb_pkg::CMD_VERSION, ssfb_pkg::CMD_BOOT_OUT: is_known = 1'b1;
			default: is_known = 1'b0;
		endcase
	endfunction : is_known

	// Codes allowed before the access code is verified
	function automatic logic is_open(input logic [7:0] c);
		is_open = (c == ssfb_pkg::CMD_STAT_RD) || (c == ssfb_pkg::CMD_ID_CHECK) ||
			(c == ssfb_pkg::CMD_VERSION);
	endfunction : is_open

	// Byte shifter on the programmer's clock
	ssfb_serial u_serial (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.sclk_pin(xfer_clock_pin),
		.sdin_pin(serial_in_pin),
		.tx_load(tx_load_q),
		.tx_data(tx_data_q),
		.sdout_q(serial_out_pin),
		.rx_byte_q(rx_byte),
		.byte_done_q(byte_done),
		.active_q(rx_active),
		.sclk_level(sclk_level)
	);

	// Version text character for the next output transfer
	ssfb_vrom u_vrom (
		.index(ver_idx_w),
		.data(ver_byte)
	);

	// Decode of the byte under inspection
	assign first_w = (idx_q == 9'h000);
	assign accept_w = is_known(rx_q) && (id_verified || flash_blank || is_open(rx_q));
	assign clear_w = (state_q == ssfb_pkg::S_DECODE) && first_w && accept_w &&
		(rx_q == ssfb_pkg::CMD_STAT_CLR);
	assign err_set_w = (state_q == ssfb_pkg::S_OP) && fl_done && fl_fail;
	assign ver_idx_w = first_w ? 3'h0 : idx_q[2:0];
	assign rd_off_w = 8'(idx_q - 9'h002);
	assign wr_off_w = 8'(idx_q - 9'h003);
	assign addr_hi_w = (idx_q == ssfb_pkg::IDX_ADDR_HI) ? rx_q : addr_hi_q;
	assign cnt_inc_w = cnt_q + 16'h0001;
	assign last_cnt_w = (cnt_inc_w == size_q);
	assign page_end_w = (idx_q == ssfb_pkg::IDX_PAGE_END);

	// Status bytes: ready flag, error results, access state
	assign status_w = (8'h01 << ssfb_pkg::SR_READY_BIT) |
		({7'h00, erase_fail_q} << ssfb_pkg::SR_ERASE_ERR_BIT) |
		({7'h00, prog_fail_q} << ssfb_pkg::SR_PROG_ERR_BIT);
	assign status_ext_w = ({7'h00, id_verified} << ssfb_pkg::SR1_ID_OK_BIT) |
		({7'h00, flash_blank} << ssfb_pkg::SR1_BLANK_BIT);

	// Error flags: a failure in the clearing cycle still sets
	always_ff @(posedge clk) begin
		if (!nrst) begin
			prog_fail_q <= 1'b0;
			erase_fail_q <= 1'b0;
		end else if (ce) begin
			prog_fail_q <= (prog_fail_q & ~clear_w) | (err_set_w & ~op_erase_q);
			erase_fail_q <= (erase_fail_q & ~clear_w) | (err_set_w & op_erase_q);
		end
	end

	// Busy until idle and no byte on the wire; programmer paces on it
	always_ff @(posedge clk) begin
		if (!nrst) begin
			busy_out_pin <= 1'b1;
		end else if (ce) begin
			busy_out_pin <= (state_q != ssfb_pkg::S_READY) || rx_active || byte_done;
		end
	end

	// Command sequencer
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_q <= ssfb_pkg::S_OFF;
			cap_cnt_q <= 2'h0;
			mode_active_q <= 1'b0;
			idx_q <= 9'h000;
			cmd_q <= 8'h00;
			rx_q <= 8'h00;
			addr_mid_q <= 8'h00;
			addr_hi_q <= 8'h00;
			size_q <= 16'h0000;
			cnt_q <= 16'h0000;
			sum_q <= 8'h00;
			chk_q <= 8'h00;
			op_erase_q <= 1'b0;
			tx_load_q <= 1'b0;
			tx_data_q <= ssfb_pkg::IDLE_TX;
			fl_addr_q <= 24'h000000;
			fl_wdata_q <= 8'h00;
			{fl_rd_q, fl_boot_q, fl_wr_q, fl_erase_blk_q} <= 4'h0;
			{fl_erase_all_q, fl_lock_prog_q, fl_lock_rd_q} <= 3'h0;
			{lock_enable_q, lock_disable_q, dl_valid_q, dl_exec_q} <= 4'h0;
			dl_data_q <= 8'h00;
		end else if (ce) begin
			tx_load_q <= 1'b0;
			{fl_rd_q, fl_wr_q, fl_erase_blk_q} <= 3'h0;
			{fl_erase_all_q, fl_lock_prog_q, fl_lock_rd_q} <= 3'h0;
			{lock_enable_q, lock_disable_q, dl_valid_q, dl_exec_q} <= 4'h0;
			unique case (state_q)
				ssfb_pkg::S_OFF: begin
					// Catch the clock level once the synchroniser has settled
					if (cap_cnt_q != ssfb_pkg::STRAP_SETTLE) begin
						cap_cnt_q <= cap_cnt_q + 2'h1;
					end else if (sclk_level && !mode_active_q) begin
						mode_active_q <= 1'b1;
						state_q <= ssfb_pkg::S_READY;
					end
				end
				ssfb_pkg::S_READY: begin
					if (byte_done) begin
						rx_q <= rx_byte;
						state_q <= ssfb_pkg::S_DECODE;
					end
				end
				ssfb_pkg::S_DECODE: begin
					state_q <= ssfb_pkg::S_READY;
					if (first_w) begin
						// Refused or unknown codes leave the index at zero
						if (accept_w) begin
							cmd_q <= rx_q;
							idx_q <= ssfb_pkg::IDX_ADDR_MID;
							if (rx_q == ssfb_pkg::CMD_STAT_RD) begin
								tx_data_q <= status_w;
								tx_load_q <= 1'b1;
							end
							if (rx_q == ssfb_pkg::CMD_VERSION) begin
								tx_data_q <= ver_byte;
								tx_load_q <= 1'b1;
							end
							if (rx_q == ssfb_pkg::CMD_STAT_CLR) begin
								idx_q <= 9'h000;
							end
							if (rx_q == ssfb_pkg::CMD_LOCK_EN) begin
								lock_enable_q <= 1'b1;
								idx_q <= 9'h000;
							end
							if (rx_q == ssfb_pkg::CMD_LOCK_DIS) begin
								lock_disable_q <= 1'b1;
								idx_q <= 9'h000;
							end
						end
					end else begin
						idx_q <= idx_q + 9'h001;
						if (idx_q == ssfb_pkg::IDX_ADDR_MID) begin
							addr_mid_q <= rx_q;
						end
						if (idx_q == ssfb_pkg::IDX_ADDR_HI) begin
							addr_hi_q <= rx_q;
						end
						unique case (cmd_q)
							ssfb_pkg::CMD_PAGE_READ, ssfb_pkg::CMD_BOOT_OUT: begin
								// Output bytes are fetched one per transfer
								if (page_end_w) begin
									idx_q <= 9'h000;
								end else if (idx_q >= ssfb_pkg::IDX_ADDR_HI) begin
									fl_addr_q <= {addr_hi_w, addr_mid_q, rd_off_w};
									fl_boot_q <= (cmd_q == ssfb_pkg::CMD_BOOT_OUT);
									fl_rd_q <= 1'b1;
									state_q <= ssfb_pkg::S_FETCH;
								end
							end
							ssfb_pkg::CMD_PAGE_PROG: begin
								if (idx_q >= ssfb_pkg::IDX_THIRD) begin
									fl_addr_q <= {addr_hi_q, addr_mid_q, wr_off_w};
									fl_wdata_q <= rx_q;
									fl_wr_q <= 1'b1;
									op_erase_q <= 1'b0;
									state_q <= ssfb_pkg::S_OP;
									if (page_end_w) begin
										idx_q <= 9'h000;
									end
								end
							end
							ssfb_pkg::CMD_BLK_ERASE, ssfb_pkg::CMD_LOCK_PROG: begin
								if (idx_q == ssfb_pkg::IDX_THIRD) begin
									idx_q <= 9'h000;
									// Act only on the confirmation byte
									if (rx_q == ssfb_pkg::CMD_CONFIRM) begin
										fl_addr_q <= {addr_hi_q, addr_mid_q, ssfb_pkg::BLOCK_TOP_LOW};
										fl_erase_blk_q <= (cmd_q == ssfb_pkg::CMD_BLK_ERASE);
										fl_lock_prog_q <= (cmd_q == ssfb_pkg::CMD_LOCK_PROG);
										op_erase_q <= (cmd_q == ssfb_pkg::CMD_BLK_ERASE);
										state_q <= ssfb_pkg::S_OP;
									end
								end
							end
							ssfb_pkg::CMD_LOCK_RD: begin
								if (idx_q == ssfb_pkg::IDX_ADDR_HI) begin
									fl_addr_q <= {rx_q, addr_mid_q, ssfb_pkg::BLOCK_TOP_LOW};
									fl_lock_rd_q <= 1'b1;
									state_q <= ssfb_pkg::S_FETCH;
								end else if (idx_q == ssfb_pkg::IDX_THIRD) begin
									idx_q <= 9'h000;
								end
							end
							ssfb_pkg::CMD_ERASE_ALL: begin
								idx_q <= 9'h000;
								if (rx_q == ssfb_pkg::CMD_CONFIRM) begin
									fl_erase_all_q <= 1'b1;
									op_erase_q <= 1'b1;
									state_q <= ssfb_pkg::S_OP;
								end
							end
							ssfb_pkg::CMD_STAT_RD: begin
								if (idx_q == ssfb_pkg::IDX_ADDR_MID) begin
									tx_data_q <= status_ext_w;
									tx_load_q <= 1'b1;
								end else begin
									idx_q <= 9'h000;
								end
							end
							ssfb_pkg::CMD_VERSION: begin
								if (idx_q == ssfb_pkg::IDX_VER_LAST) begin
									idx_q <= 9'h000;
								end else begin
									tx_data_q <= ver_byte;
									tx_load_q <= 1'b1;
								end
							end
							ssfb_pkg::CMD_DOWNLOAD: begin
								// Size low, size high, checksum, then data
								if (idx_q == ssfb_pkg::IDX_ADDR_MID) begin
									size_q[7:0] <= rx_q;
								end else if (idx_q == ssfb_pkg::IDX_ADDR_HI) begin
									size_q[15:8] <= rx_q;
								end else if (idx_q == ssfb_pkg::IDX_THIRD) begin
									chk_q <= rx_q;
									sum_q <= 8'h00;
									cnt_q <= 16'h0000;
									if (size_q == 16'h0000) begin
										idx_q <= 9'h000;
										dl_exec_q <= (rx_q == 8'h00);
									end
								end else begin
									idx_q <= ssfb_pkg::IDX_FOURTH;
									dl_valid_q <= 1'b1;
									dl_data_q <= rx_q;
									sum_q <= sum_q + rx_q;
									cnt_q <= cnt_inc_w;
									if (last_cnt_w) begin
										idx_q <= 9'h000;
										dl_exec_q <= ((sum_q + rx_q) == chk_q);
									end
								end
							end
							ssfb_pkg::CMD_ID_CHECK: begin
								// Address, length, then the code bytes are consumed
								if (idx_q == ssfb_pkg::IDX_FOURTH) begin
									size_q <= {8'h00, rx_q};
									cnt_q <= 16'h0000;
									if (rx_q == 8'h00) begin
										idx_q <= 9'h000;
									end
								end else if (idx_q >= ssfb_pkg::IDX_FIFTH) begin
									idx_q <= ssfb_pkg::IDX_FIFTH;
									cnt_q <= cnt_inc_w;
									if (last_cnt_w) begin
										idx_q <= 9'h000;
									end
								end
							end
							default: begin
								idx_q <= 9'h000;
							end
						endcase
					end
				end
				ssfb_pkg::S_FETCH: begin
					// Read data goes out on the next transfer
					if (fl_done) begin
						tx_data_q <= fl_rdata;
						tx_load_q <= 1'b1;
						state_q <= ssfb_pkg::S_READY;
					end
				end
				ssfb_pkg::S_OP: begin
					if (fl_done) begin
						state_q <= ssfb_pkg::S_READY;
					end
				end
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_in_decode;
		ce && state_q == ssfb_pkg::S_DECODE;
	endsequence

	sequence s_ea_confirm;
		s_in_decode ##0 cmd_q == ssfb_pkg::CMD_ERASE_ALL && idx_q == 9'h001;
	endsequence

	property p_mode_entry;
		ce && state_q == ssfb_pkg::S_OFF && cap_cnt_q == 2'h3 && sclk_level
			|=> state_q == ssfb_pkg::S_READY && mode_active_q;
	endproperty
	a_mode_entry: assert property (p_mode_entry) else $error("mode not entered");

	property p_busy;
		ce && (rx_active || state_q != ssfb_pkg::S_READY) |=> busy_out_pin;
	endproperty
	a_busy: assert property (p_busy) else $error("busy low while occupied");

	property p_refuse;
		s_in_decode ##0 idx_q == 9'h000 && !id_verified && !flash_blank &&
			rx_q == ssfb_pkg::CMD_PAGE_READ |=> idx_q == 9'h000 && !fl_rd_q;
	endproperty
	a_refuse: assert property (p_refuse) else $error("locked command accepted");

	property p_blank;
		s_in_decode ##0 idx_q == 9'h000 && flash_blank && !id_verified &&
			rx_q == ssfb_pkg::CMD_BOOT_OUT |=> idx_q == 9'h001 && cmd_q == ssfb_pkg::CMD_BOOT_OUT;
	endproperty
	a_blank: assert property (p_blank) else $error("blank flash refused command");

	property p_page_addr;
		fl_rd_q && cmd_q == ssfb_pkg::CMD_PAGE_READ
			|-> fl_addr_q[7:0] == 8'(idx_q - 9'h003) && fl_addr_q[15:8] == addr_mid_q;
	endproperty
	a_page_addr: assert property (p_page_addr) else $error("page read address wrong");

	property p_status;
		s_in_decode ##0 idx_q == 9'h000 && rx_q == ssfb_pkg::CMD_STAT_RD
			|=> tx_load_q && tx_data_q == $past(status_w);
	endproperty
	a_status: assert property (p_status) else $error("status byte not loaded");

	property p_erase_all;
		s_ea_confirm |=> fl_erase_all_q == ($past(rx_q) == ssfb_pkg::CMD_CONFIRM);
	endproperty
	a_erase_all: assert property (p_erase_all) else $error("erase all confirm wrong");

	property p_clear;
		ce && clear_w |=> !prog_fail_q && !erase_fail_q && idx_q == 9'h000;
	endproperty
	a_clear: assert property (p_clear) else $error("error bits not cleared");

	property p_version_end;
		s_in_decode ##0 cmd_q == ssfb_pkg::CMD_VERSION && idx_q == 9'h008
			|=> idx_q == 9'h000 && !tx_load_q;
	endproperty
	a_version_end: assert property (p_version_end) else $error("version overran");

	property p_prog;
		s_in_decode ##0 cmd_q == ssfb_pkg::CMD_PAGE_PROG && idx_q >= 9'h003
			|=> fl_wr_q && fl_wdata_q == $past(rx_q) && state_q == ssfb_pkg::S_OP;
	endproperty
	a_prog: assert property (p_prog) else $error("page program byte lost");
endmodule : ssfb_top

// File: rtl/ssfb_pkg.sv
// Constants and types of the synchronous serial flash boot command interpreter
package ssfb_pkg;
	// Command codes
	localparam logic [7:0] CMD_PAGE_READ = 8'hFF;
	localparam logic [7:0] CMD_PAGE_PROG = 8'h41;
	localparam logic [7:0] CMD_BLK_ERASE = 8'h20;
	localparam logic [7:0] CMD_ERASE_ALL = 8'hA7;
	localparam logic [7:0] CMD_STAT_RD = 8'h70;
	localparam logic [7:0] CMD_STAT_CLR = 8'h50;
	localparam logic [7:0] CMD_LOCK_RD = 8'h71;
	localparam logic [7:0] CMD_LOCK_PROG = 8'h77;
	localparam logic [7:0] CMD_LOCK_EN = 8'h7A;
	localparam logic [7:0] CMD_LOCK_DIS = 8'h75;
	localparam logic [7:0] CMD_ID_CHECK = 8'hF5;
	localparam logic [7:0] CMD_DOWNLOAD = 8'hFA;
	localparam logic [7:0] CMD_VERSION = 8'hFB;
	localparam logic [7:0] CMD_BOOT_OUT = 8'hFC;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0;
	// Serial framing
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [7:0] IDLE_TX = 8'hFF;
	// Transfer indices within a command
	localparam logic [8:0] IDX_ADDR_MID = 9'h001;
	localparam logic [8:0] IDX_ADDR_HI = 9'h002;
	localparam logic [8:0] IDX_THIRD = 9'h003;
	localparam logic [8:0] IDX_FOURTH = 9'h004;
	localparam logic [8:0] IDX_FIFTH = 9'h005;
	localparam logic [8:0] IDX_VER_LAST = 9'h008;
	localparam logic [8:0] IDX_PAGE_END = 9'h102;
	localparam logic [7:0] BLOCK_TOP_LOW = 8'hFF;
	// Status byte fields
	localparam int SR_READY_BIT = 7;
	localparam int SR_ERASE_ERR_BIT = 5;
	localparam int SR_PROG_ERR_BIT = 4;
	// Extended status byte fields
	localparam int SR1_ID_OK_BIT = 2;
	localparam int SR1_BLANK_BIT = 0;
	// Cycles after reset release before the mode strap is caught
	localparam logic [1:0] STRAP_SETTLE = 2'h3;
	// Version text, arbitrary value
	localparam logic [63:0] VERSION_TEXT = 64'h3030_3031_2E52_4556;
	typedef enum logic [4:0] {
		S_OFF = 5'b00001,
		S_READY = 5'b00010,
		S_DECODE = 5'b00100,
		S_FETCH = 5'b01000,
		S_OP = 5'b10000
	} ssfb_state_t;
endpackage : ssfb_pkg

// File: rtl/ssfb_vrom.sv
// Eight-byte version text lookup
module ssfb_vrom (
	input wire logic [2:0] index,
	output logic [7:0] data
);
	logic [7:0] text_mem [0:7];

	// Unpack the version text, first character in the low byte
	for (genvar g = 0; g < 8; g++) begin : g_text
		assign text_mem[g] = ssfb_pkg::VERSION_TEXT[g*8 +: 8];
	end
	assign data = text_mem[index];
endmodule : ssfb_vrom

// File: rtl/ssfb_serial.sv
// Clock-synchronous byte shifter on an externally driven transfer clock
module ssfb_serial (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic sclk_pin,
	input wire logic sdin_pin,
	input wire logic tx_load,
	input wire logic [7:0] tx_data,
	output logic sdout_q,
	output logic [7:0] rx_byte_q,
	output logic byte_done_q,
	output logic active_q,
	output logic sclk_level
);
	logic sclk_s1_q, sclk_s2_q, sclk_s3_q, sdin_s1_q, sdin_s2_q;
	logic [7:0] rx_sh_q;
	logic [7:0] tx_sh_q;
	logic [2:0] bit_cnt_q;
	logic rise_w, fall_w;

	// Two-stage synchronisers, third stage for edge finding
	always_ff @(posedge clk) begin
		if (!nrst) begin
			{sclk_s1_q, sclk_s2_q, sclk_s3_q} <= 3'h7; // Idle high, no false rise after reset
			{sdin_s1_q, sdin_s2_q} <= 2'h0;
		end else if (ce) begin
			{sclk_s1_q, sclk_s2_q, sclk_s3_q} <= {sclk_pin, sclk_s1_q, sclk_s2_q};
			{sdin_s1_q, sdin_s2_q} <= {sdin_pin, sdin_s1_q};
		end
	end

	assign rise_w = sclk_s2_q & ~sclk_s3_q;
	assign fall_w = ~sclk_s2_q & sclk_s3_q;
	assign sclk_level = sclk_s2_q;

	// Receive on rising edges, LSB first
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rx_sh_q <= 8'h00;
			rx_byte_q <= 8'h00;
			bit_cnt_q <= 3'h0;
			byte_done_q <= 1'b0;
			active_q <= 1'b0;
		end else if (ce) begin
			byte_done_q <= 1'b0;
			if (fall_w) begin
				active_q <= 1'b1;
			end
			if (rise_w) begin
				rx_sh_q <= {sdin_s2_q, rx_sh_q[7:1]};
				bit_cnt_q <= bit_cnt_q + 3'h1;
				if (bit_cnt_q == ssfb_pkg::LAST_BIT) begin
					rx_byte_q <= {sdin_s2_q, rx_sh_q[7:1]};
					byte_done_q <= 1'b1;
					active_q <= 1'b0;
				end
			end
		end
	end

	// Transmit on falling edges; ones refill so an idle line reads high
	always_ff @(posedge clk) begin
		if (!nrst) begin
			tx_sh_q <= ssfb_pkg::IDLE_TX;
			sdout_q <= 1'b1;
		end else if (ce) begin
			if (tx_load) begin
				tx_sh_q <= tx_data;
			end else if (fall_w) begin
				sdout_q <= tx_sh_q[0];
				tx_sh_q <= {1'b1, tx_sh_q[7:1]};
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_rx_sample;
		ce && rise_w |=> rx_sh_q[7] == $past(sdin_s2_q);
	endproperty
	a_rx_sample: assert property (p_rx_sample) else $error("rx bit not taken on rise");

	property p_tx_drive;
		ce && fall_w && !tx_load |=> sdout_q == $past(tx_sh_q[0]);
	endproperty
	a_tx_drive: assert property (p_tx_drive) else $error("tx bit not driven on fall");

	property p_byte_len;
		ce && rise_w && bit_cnt_q == 3'h7 |=> byte_done_q && !active_q;
	endproperty
	a_byte_len: assert property (p_byte_len) else $error("byte not closed after 8 bits");
endmodule : ssfb_serial

// File: sim/ssfb_prog_model.sv
// Programmer model: drives the transfer clock and serial data, reads the device output
module ssfb_prog_model (
	input wire logic clk,
	input wire logic busy_out_pin,
	input wire logic serial_out_pin,
	output logic xfer_clock_pin,
	output logic serial_in_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic timed_out;
	// Clock idles high across reset release
	initial begin
		xfer_clock_pin = 1'b1;
		serial_in_pin = 1'b1;
		timed_out = 1'b0;
	end
	// One byte each way, 80 ns bit period, started once busy is low or after 4000 cycles of waiting
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		int n;
		n = 0;
		while (busy_out_pin !== 1'b0 && n < 4000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 4000) timed_out = 1'b1;
		#3;
		for (int i = 0; i < 8; i++) begin
			xfer_clock_pin = 1'b0;
			serial_in_pin = tx[i];
			#40;
			xfer_clock_pin = 1'b1;
			rx[i] = serial_out_pin;
			#40;
		end
		// Released data line shows the inverse of the last bit
		serial_in_pin = ~tx[7];
	endtask : xfer
endmodule : ssfb_prog_model

// File: sim/sync_serial_flash_boot_protocol_test.sv
// Self-checking bench for the serial flash boot command interpreter
module sync_serial_flash_boot_protocol_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, fl_done = 1'b0, fl_fail = 1'b0;
	logic flash_blank = 1'b0, id_verified = 1'b0, fail_next = 1'b0;
	logic [7:0] fl_rdata = 8'h00;
	logic sclk, sdin, sdout, busy, mode, boot;
	logic [23:0] addr;
	logic [7:0] wdata, dl_data, rx, m, h, s;
	logic [7:0] dq [256];
	logic [9:0] req;
	logic [7:0] wq [$];
	int cnt [10];
	int error_cnt = 0, n_tests = 0, lat = 0;
	// Clock
	always #5 clk = ~clk;
	ssfb_top DUT (.clk(clk), .nrst(nrst), .ce(ce), .xfer_clock_pin(sclk), .serial_in_pin(sdin),
		.fl_rdata(fl_rdata), .fl_done(fl_done), .fl_fail(fl_fail), .flash_blank(flash_blank),
		.id_verified(id_verified), .serial_out_pin(sdout), .busy_out_pin(busy),
		.mode_active_q(mode), .fl_addr_q(addr), .fl_wdata_q(wdata), .fl_rd_q(req[0]),
		.fl_boot_q(boot), .fl_wr_q(req[1]), .fl_erase_blk_q(req[2]), .fl_erase_all_q(req[3]),
		.fl_lock_prog_q(req[4]), .fl_lock_rd_q(req[5]), .lock_enable_q(req[8]),
		.lock_disable_q(req[9]), .dl_valid_q(req[6]), .dl_data_q(dl_data), .dl_exec_q(req[7]));
	ssfb_prog_model P (.clk(clk), .busy_out_pin(busy), .serial_out_pin(sdout),
		.xfer_clock_pin(sclk), .serial_in_pin(sdin));
	// Array contents as a function of address and area
	function automatic logic [7:0] mem(input logic [23:0] a, input logic b);
		return a[7:0] + a[15:8] + a[23:16] + (b ? 8'h33 : 8'h00);
	endfunction : mem
	// Pulse tally and flash model answering after 1 to 3 cycles
	always @(posedge clk) begin
		fl_done <= 1'b0;
		for (int i = 0; i < 10; i++) if (req[i] === 1'b1) cnt[i]++;
		if (req[1] === 1'b1) wq.push_back(wdata);
		if (lat > 1) lat <= lat - 1;
		else if (lat == 1) begin
			lat <= 0;
			fl_done <= 1'b1;
			fl_fail <= fail_next;
			fl_rdata <= mem(addr, boot);
		end else if (|req[5:0]) lat <= 1 + $urandom % 3;
	end
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_byte
	// Waits for the device to go idle, then checks a pulse count
	task automatic chk_cnt(input int idx, input int exp);
		for (int n = 0; n < 4000 && busy !== 1'b0; n++) @(posedge clk);
		n_tests++;
		if (cnt[idx] != exp || busy !== 1'b0) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, cnt[idx], exp);
		end
		cnt = '{default: 0};
	endtask : chk_cnt
	task automatic setin(input logic id, input logic blank, input logic fail);
		@(posedge clk);
		ce <= 1'b0; // Freeze a few idle cycles
		id_verified <= id;
		flash_blank <= blank;
		fail_next <= fail;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
	endtask : setin
	task automatic send(input logic [7:0] q [$]);
		foreach (q[i]) P.xfer(q[i], rx);
	endtask : send
	task automatic status(input logic [7:0] e0, input logic [7:0] e1);
		send('{ssfb_pkg::CMD_STAT_RD, 8'h00});
		chk_byte(rx, e0);
		P.xfer(8'h00, rx);
		chk_byte(rx, e1);
	endtask : status
	// Page read or boot output: command, middle, high, then 256 bytes
	task automatic page(input logic [7:0] c, input logic b);
		m = $urandom;
		h = $urandom;
		send('{c, m, h});
		for (int i = 0; i < 256; i++) begin
			P.xfer(8'h00, rx);
			chk_byte(rx, mem({h, m, i[7:0]}, b));
		end
	endtask : page
	task automatic results();
		if (P.timed_out) error_cnt++;
		if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : results
	// Watchdog, about one and a half times the expected run
	initial begin
		#900us;
		error_cnt++;
		results();
	end
	// Main sequence
	initial begin
		void'($urandom(39));
		cnt = '{default: 0};
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (12) @(posedge clk);
		chk_byte({7'h00, mode}, 8'h01);
		P.xfer(ssfb_pkg::CMD_VERSION, rx);
		for (int i = 0; i < 8; i++) begin
			P.xfer(8'h00, rx);
			chk_byte(rx, ssfb_pkg::VERSION_TEXT[8*i+:8]);
		end
		P.xfer(ssfb_pkg::CMD_PAGE_READ, rx);
		chk_cnt(0, 0);
		status(8'h80, 8'h00);
		setin(1'b1, 1'b0, 1'b0);
		page(ssfb_pkg::CMD_PAGE_READ, 1'b0);
		setin(1'b1, 1'b0, 1'b1);
		send('{ssfb_pkg::CMD_PAGE_PROG, m, h});
		for (int i = 0; i < 256; i++) begin
			dq[i] = $urandom;
			P.xfer(dq[i], rx);
		end
		chk_cnt(1, 256);
		for (int i = 0; i < 256; i++) chk_byte(wq[i], dq[i]);
		chk_byte(addr[15:8], m);
		setin(1'b1, 1'b0, 1'b0);
		status(8'h90, 8'h04);
		P.xfer(ssfb_pkg::CMD_STAT_CLR, rx);
		status(8'h80, 8'h04);
		send('{8'hA7, 8'h00});
		chk_cnt(3, 0);
		send('{8'hA7, 8'hD0});
		chk_cnt(3, 1);
		send('{8'h20, m, h, 8'hD0});
		chk_cnt(2, 1);
		chk_byte(addr[23:16], h);
		send('{8'h77, h, m, 8'hD0});
		chk_cnt(4, 1);
		P.xfer(8'h7A, rx);
		chk_cnt(8, 1);
		P.xfer(8'h75, rx);
		chk_cnt(9, 1);
		setin(1'b0, 1'b1, 1'b0);
		send('{8'h71, m, h, 8'h00});
		chk_byte(rx, mem({h, m, 8'hFF}, 1'b0));
		chk_cnt(5, 1);
		s = $urandom;
		dq[0] = $urandom;
		send('{8'hFA, 8'h03, 8'h00, dq[0] + s + 8'h01, dq[0], s, 8'h01});
		chk_cnt(6, 3);
		send('{8'hFA, 8'h01, 8'h00, 8'h07, 8'h07});
		chk_cnt(7, 1);
		chk_byte(dl_data, 8'h07);
		send('{ssfb_pkg::CMD_ID_CHECK, 8'h00, 8'h00, 8'h00, 8'h01, 8'h55});
		status(8'h80, 8'h01);
		page(ssfb_pkg::CMD_BOOT_OUT, 1'b1);
		results();
	end
endmodule : sync_serial_flash_boot_protocol_test
